/* File: verilog/linio_pkg.sv */
// linio_pkg: shared constants and types for the LIN I/O pin and transceiver control block
package linio_pkg;
    localparam int          NUM_PINS        = 8;
    localparam logic [3:0]  ADDR_PIN_HS_EN  = 4'h0;
    localparam logic [3:0]  ADDR_PIN_LS_EN  = 4'h1;
    localparam logic [3:0]  ADDR_LATCH      = 4'h2;
    localparam logic [3:0]  ADDR_THR_SEL    = 4'h3;
    localparam logic [3:0]  ADDR_EDGE_SEL   = 4'h4;
    localparam logic [3:0]  ADDR_INH_CTRL   = 4'h5;
    localparam logic [3:0]  ADDR_MODE_CTRL  = 4'h6;
    localparam logic [3:0]  ADDR_EDGE_FLAGS = 4'h7;
    localparam logic [3:0]  ADDR_PIN_IN     = 4'h8;
    localparam logic [3:0]  ADDR_STATUS     = 4'h9;
    localparam logic [15:0] RST_EDGE_SEL    = 16'h0000;
    localparam logic [1:0]  INH_RST_MODE    = 2'h0;
    // dominant timeout in microseconds, converted at 125 MHz (8 ns)
    localparam int          DOM_TIMEOUT_US  = 6000;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          DOM_TIMEOUT_CYC = (DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int          DOM_CNT_W       = 24;
    localparam int          SYNC_STAGES     = 3;
    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH
    } linio_edge_t;
    typedef enum logic [1:0] {
        DEV_CONFIG,
        DEV_NORMAL,
        DEV_STANDBY,
        DEV_LOWPWR
    } linio_devmode_t;
    typedef enum {
        XCV_OFFLINE,
        XCV_ACTIVE,
        XCV_FAILSIL
    } linio_xcv_t;
endpackage : linio_pkg

/* File: verilog/linio_sync.sv */
// linio_sync: three-stage input synchroniser with change qualification
`timescale 1ns/1ps
`default_nettype none
module linio_sync
    import linio_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } linio_sync_st_t;
    linio_sync_st_t st_q, st_d;

    // the level only moves once stages two and three agree
    always_comb begin
        st_d     = st_q;
        st_d.s1  = async;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
endmodule : linio_sync
`default_nettype wire

/* File: verilog/linio_pin_xcv_ctrl.sv */
// linio_pin_xcv_ctrl: I/O pin, inhibit, config pin and LIN transceiver control
//
// Contract
// - both enables 0 high-z; one enable switches per latch; both push-pull.
// - cyclic sense: high-side-only pin latch 0 off phase, 1 on phase.
// - threshold-select 0 picks first threshold, 1 second; resets to 0.
// - edge capture none, fall, rise or both; reset none; only selected set flag.
// - cyclic sense with second threshold uses third threshold in on phase.
// - inhibit has three modes; reset in external regulator, switch on.
// - config pull-ups only during address configuration, else high impedance.
// - daisy chain config drives third config pin low-side with chain output.
// - reset enters Off-line, tx and rx off, wake-up still detected.
// - wake-up in Sleep goes to controller, Normal, transceiver Active.
// - transmitter enabled only in Active mode.
// - Active closes termination; dominant beyond timeout opens it, Fail silent.
// - Fail silent, bus recessive: go Off-line with weak termination only.
// - every Off-line to Active transition closes full termination switch.
// - slow or stopped oscillator enters Limp home at once.
// - inhibit select both 0 external regulator; hi 0 lo 1 converter sampling.
// - external regulator drives high in Config/Normal/Standby, else high-z; code also releases it to high-z in limp home.
`timescale 1ns/1ps
`default_nettype none
module linio_pin_xcv_ctrl
    import linio_pkg::*;
#(
    parameter int DOM_TIMEOUT = DOM_TIMEOUT_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [3:0]           regAddr,
    input  wire logic [15:0]          regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [15:0]          regRdata,
    input  wire logic [NUM_PINS-1:0]  pinIn,
    input  wire logic                 busRxd,
    input  wire logic                 busWake,
    input  wire logic                 oscFail,
    input  wire logic                 cyclicSense,
    input  wire logic                 chainOut,
    output logic [NUM_PINS-1:0]       pinHsOn,
    output logic [NUM_PINS-1:0]       pinLsOn,
    output logic [NUM_PINS-1:0]       thrSecond,
    output logic [NUM_PINS-1:0]       thrThird,
    output logic                      inhibitOutput,
    output logic                      inhibitOe,
    output logic                      inhibitAdc,
    output logic [2:0]                configPinPullup,
    output logic                      chainLsOn,
    output logic                      txEnable,
    output logic                      rxEnable,
    output logic                      busTerminationSwitch,
    output logic                      weakTermination,
    output logic                      wakeToCtrl,
    output logic                      limpHome
);
    ////////////////////////////////////////////////////////////////////////////////////
    // whole block state in one packed struct, registered by one process
    typedef struct packed {
        logic [NUM_PINS-1:0]   hsEn;
        logic [NUM_PINS-1:0]   lsEn;
        logic [NUM_PINS-1:0]   latch;
        logic [NUM_PINS-1:0]   thrSel;
        logic [2*NUM_PINS-1:0] edgeSel;
        logic [NUM_PINS-1:0]   edgeFlag;
        logic [NUM_PINS-1:0]   pinPrev;
        logic                  inhibitModeSelLo;
        logic                  inhibitModeSelHi;
        logic                  nadCfg;
        logic                  chainCfg;
        linio_devmode_t        devMode;
        linio_xcv_t            xcv;
        logic [DOM_CNT_W-1:0]  domCnt;
        logic                  limp;
        logic                  wakeOut;
        logic [15:0]           rdata;
        logic [NUM_PINS-1:0]   hsOn;
        logic [NUM_PINS-1:0]   lsOn;
        logic [NUM_PINS-1:0]   thr2;
        logic [NUM_PINS-1:0]   thr3;
        logic                  inhOut;
        logic                  inhOe;
        logic                  inhAdc;
        logic [2:0]            cfgPu;
        logic                  chainLs;
        logic                  txEn;
        logic                  rxEn;
        logic                  term;
        logic                  weakTerm;
    } linio_st_t;
    linio_st_t st_q, st_d;

    logic [NUM_PINS-1:0] pinSync;
    logic [2:0]          ctlSync;

    // pins, bus and oscillator monitor come from outside this clock domain
    // the bus level is synced inverted so that reset reads as recessive, not dominant
    linio_sync #(.W(NUM_PINS)) u_pin_sync (
        .clk   (clk),
        .reset (reset),
        .async (pinIn),
        .level (pinSync)
    );
    linio_sync #(.W(3)) u_ctl_sync (
        .clk   (clk),
        .reset (reset),
        .async ({oscFail, busWake, ~busRxd}),
        .level (ctlSync)
    );

    // named views of the synced control inputs
    logic recessive;
    logic wakeEvt;
    logic oscBad;
    assign recessive = ~ctlSync[0];
    assign wakeEvt   = ctlSync[1];
    assign oscBad    = ctlSync[2];

    ////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [1:0]  esel;
        logic        rise;
        logic        fall;
        logic        domTo;
        // locals cleared first so no latch is inferred
        esel  = 2'h0;
        rise  = 1'b0;
        fall  = 1'b0;
        domTo = 1'b0;
        st_d  = st_q;
        st_d.wakeOut = 1'b0;

        // register writes
        // unmapped indices fall through the default and change nothing
        if (regWrite) begin
            case (regAddr)
                ADDR_PIN_HS_EN: st_d.hsEn = regWdata[NUM_PINS-1:0];
                ADDR_PIN_LS_EN: st_d.lsEn = regWdata[NUM_PINS-1:0];
                ADDR_LATCH:     st_d.latch = regWdata[NUM_PINS-1:0];
                ADDR_THR_SEL:   st_d.thrSel = regWdata[NUM_PINS-1:0];
                ADDR_EDGE_SEL:  st_d.edgeSel = regWdata;
                ADDR_INH_CTRL: begin
                    st_d.inhibitModeSelLo = regWdata[0];
                    st_d.inhibitModeSelHi = regWdata[1];
                end
                ADDR_MODE_CTRL: begin
                    st_d.devMode  = linio_devmode_t'(regWdata[1:0]);
                    st_d.nadCfg   = regWdata[2];
                    st_d.chainCfg = regWdata[3];
                end
                ADDR_EDGE_FLAGS: st_d.edgeFlag = st_q.edgeFlag & ~regWdata[NUM_PINS-1:0];
                default: ;
            endcase
        end

        // edge capture; a new edge wins over a same-cycle clear
        // pinPrev and the synced level both reset to zero: no false edge after reset
        st_d.pinPrev = pinSync;
        for (int i = 0; i < NUM_PINS; i++) begin
            esel = st_q.edgeSel[2*i +: 2];
            rise = pinSync[i] & ~st_q.pinPrev[i];
            fall = ~pinSync[i] & st_q.pinPrev[i];
            if ((rise && (esel == EDGE_RISE || esel == EDGE_BOTH)) ||
                (fall && (esel == EDGE_FALL || esel == EDGE_BOTH))) begin
                st_d.edgeFlag[i] = 1'b1;
            end
        end

        // pin driver decode: a single enable follows the latch as a switch
        // push-pull takes the inverted latch on the low side, never both on
        for (int i = 0; i < NUM_PINS; i++) begin
            st_d.hsOn[i] = st_q.hsEn[i] & st_q.latch[i];
            st_d.lsOn[i] = st_q.lsEn[i] & (st_q.hsEn[i] ? ~st_q.latch[i]
                                                        : st_q.latch[i]);
            st_d.thr2[i] = st_q.thrSel[i];
            // third threshold only in the cyclic sense on phase
            st_d.thr3[i] = cyclicSense & st_q.thrSel[i] & st_q.hsEn[i]
                         & ~st_q.lsEn[i] & st_q.latch[i];
        end

        // oscillator failure forces limp home with no delay beyond the sync
        // a wake is held off while the oscillator still fails, so limp home sticks
        if (oscBad) begin
            st_d.limp    = 1'b1;
            st_d.devMode = DEV_LOWPWR;
        end

        // transceiver mode machine
        // the dominant counter saturates at the terminal count instead of wrapping
        domTo = (st_q.domCnt >= DOM_CNT_W'(DOM_TIMEOUT));
        if (recessive) begin
            st_d.domCnt = '0;
        end else if (!domTo) begin
            st_d.domCnt = st_q.domCnt + 1'b1;
        end
        case (st_q.xcv)
            XCV_OFFLINE: begin
                if (wakeEvt && !oscBad) begin
                    st_d.wakeOut = 1'b1;
                    st_d.devMode = DEV_NORMAL;
                    st_d.limp    = 1'b0;
                    st_d.xcv     = XCV_ACTIVE;
                end else if (st_q.devMode == DEV_NORMAL && !st_q.limp) begin
                    st_d.xcv = XCV_ACTIVE;
                end
            end
            XCV_ACTIVE: begin
                if (domTo) begin
                    st_d.xcv = XCV_FAILSIL;
                end else if (st_q.devMode == DEV_LOWPWR) begin
                    st_d.xcv = XCV_OFFLINE;
                end
            end
            XCV_FAILSIL: begin
                if (recessive) begin
                    st_d.xcv = XCV_OFFLINE;
                end
            end
            default: st_d.xcv = XCV_OFFLINE;
        endcase
        // enables follow the next mode so they switch with it, not a cycle later
        st_d.txEn     = (st_d.xcv == XCV_ACTIVE);
        st_d.rxEn     = (st_d.xcv == XCV_ACTIVE);
        st_d.term     = (st_d.xcv == XCV_ACTIVE);
        st_d.weakTerm = (st_d.xcv == XCV_OFFLINE);

        // inhibit pin: external regulator, converter sampling, switch open
        // both select bits high is not a defined mode and acts as switch open
        st_d.inhAdc = st_q.inhibitModeSelLo & ~st_q.inhibitModeSelHi;
        st_d.inhOut = 1'b0;
        st_d.inhOe  = 1'b0;
        if (!st_q.inhibitModeSelLo && !st_q.inhibitModeSelHi) begin
            // regulator supply is released in low-power mode and in limp home
            st_d.inhOut = (st_q.devMode != DEV_LOWPWR) && !st_q.limp;
            st_d.inhOe  = st_d.inhOut;
        end

        // configuration pins
        // the pin follows the chain output: low side on pulls it low for a zero
        st_d.cfgPu   = {3{st_q.nadCfg}};
        st_d.chainLs = st_q.chainCfg & ~chainOut;

        // register read data, returned one cycle after the strobe
        // reads have no side effects; edge flags clear only by writing ones
        st_d.rdata = 16'h0000;
        if (regRead) begin
            case (regAddr)
                ADDR_PIN_HS_EN:  st_d.rdata = {8'h00, st_q.hsEn};
                ADDR_PIN_LS_EN:  st_d.rdata = {8'h00, st_q.lsEn};
                ADDR_LATCH:      st_d.rdata = {8'h00, st_q.latch};
                ADDR_THR_SEL:    st_d.rdata = {8'h00, st_q.thrSel};
                ADDR_EDGE_SEL:   st_d.rdata = st_q.edgeSel;
                ADDR_INH_CTRL:   st_d.rdata = {14'h0000, st_q.inhibitModeSelHi,
                                               st_q.inhibitModeSelLo};
                ADDR_MODE_CTRL:  st_d.rdata = {12'h000, st_q.chainCfg, st_q.nadCfg,
                                               st_q.devMode};
                ADDR_EDGE_FLAGS: st_d.rdata = {8'h00, st_q.edgeFlag};
                ADDR_PIN_IN:     st_d.rdata = {8'h00, pinSync};
                ADDR_STATUS:     st_d.rdata = {13'h0000, st_q.limp, st_q.xcv[1:0]};
                default:         st_d.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // everything resets to zero: high-z pins, first threshold, no capture
    // except inhibit, driven high, and the weak bus termination
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q         <= '0;
            st_q.edgeSel <= RST_EDGE_SEL;
            st_q.devMode <= DEV_CONFIG;
            st_q.xcv     <= XCV_OFFLINE;
            st_q.weakTerm<= 1'b1;
            st_q.inhOut  <= 1'b1;
            st_q.inhOe   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // every output is a flop of the state struct; nothing combinational leaves
    assign regRdata             = st_q.rdata;
    assign pinHsOn              = st_q.hsOn;
    assign pinLsOn              = st_q.lsOn;
    assign thrSecond            = st_q.thr2;
    assign thrThird             = st_q.thr3;
    assign inhibitOutput        = st_q.inhOut;
    assign inhibitOe            = st_q.inhOe;
    assign inhibitAdc           = st_q.inhAdc;
    assign configPinPullup      = st_q.cfgPu;
    assign chainLsOn            = st_q.chainLs;
    assign txEnable             = st_q.txEn;
    assign rxEnable             = st_q.rxEn;
    assign busTerminationSwitch = st_q.term;
    assign weakTermination      = st_q.weakTerm;
    assign wakeToCtrl           = st_q.wakeOut;
    assign limpHome             = st_q.limp;
endmodule : linio_pin_xcv_ctrl
`default_nettype wire

/* File: dv/linio_pin_xcv_ctrl_sva.sv */
// linio_pin_xcv_ctrl_sva: port-level checks for pin and transceiver control
`timescale 1ns/1ps
`default_nettype none
module linio_pin_xcv_ctrl_sva
    import linio_pkg::*;
#(
    parameter int DOM_TIMEOUT = DOM_TIMEOUT_CYC
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                busRxd,
    input wire logic                oscFail,
    input wire logic [NUM_PINS-1:0] pinHsOn,
    input wire logic [NUM_PINS-1:0] pinLsOn,
    input wire logic [NUM_PINS-1:0] thrSecond,
    input wire logic [NUM_PINS-1:0] thrThird,
    input wire logic                inhibitOutput,
    input wire logic                inhibitOe,
    input wire logic [2:0]          configPinPullup,
    input wire logic                txEnable,
    input wire logic                busTerminationSwitch,
    input wire logic                weakTermination,
    input wire logic                wakeToCtrl,
    input wire logic                limpHome
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    int domCnt;
    // dominant run seen while transmitting; slack covers sync and register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            domCnt <= 0;
        end else begin
            domCnt <= (busRxd || !txEnable) ? 0 : domCnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_push_pull; (pinHsOn & pinLsOn) == '0; endproperty
    a_push_pull: assert property (p_push_pull) else $error("both switches on");
    property p_third; (thrThird & ~(thrSecond & pinHsOn & ~pinLsOn)) == '0; endproperty
    a_third: assert property (p_third) else $error("third threshold misused");
    property p_cfg; configPinPullup == 3'h0 || configPinPullup == 3'h7; endproperty
    a_cfg: assert property (p_cfg) else $error("pull-ups split");
    property p_tx_term; txEnable |-> busTerminationSwitch && !weakTermination; endproperty
    a_tx_term: assert property (p_tx_term) else $error("tx without termination");
    property p_wake_active; wakeToCtrl |=> !wakeToCtrl ##[0:3] txEnable; endproperty
    a_wake_active: assert property (p_wake_active) else $error("wake not active");
    property p_dom; domCnt <= DOM_TIMEOUT + 8; endproperty
    a_dom: assert property (p_dom) else $error("dominant timeout missed");
    property p_limp; oscFail [*8] |-> limpHome; endproperty
    a_limp: assert property (p_limp) else $error("no limp home");
    property p_inh_rst; $fell(reset) |-> inhibitOe && inhibitOutput && weakTermination; endproperty
    a_inh_rst: assert property (p_inh_rst) else $error("bad reset state");
endmodule : linio_pin_xcv_ctrl_sva
bind linio_pin_xcv_ctrl linio_pin_xcv_ctrl_sva #(.DOM_TIMEOUT(DOM_TIMEOUT)) chk (.clk, .reset,
    .busRxd, .oscFail, .pinHsOn, .pinLsOn, .thrSecond, .thrThird, .inhibitOutput, .inhibitOe,
    .configPinPullup, .txEnable, .busTerminationSwitch, .weakTermination, .wakeToCtrl,
    .limpHome);
`default_nettype wire

/* File: dv/linio_far_side.sv */
// linio_far_side: bus master and external switch model
`timescale 1ns/1ps
`default_nettype none
module linio_far_side
    import linio_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pinHsOn,
    input  wire logic [NUM_PINS-1:0] pinLsOn,
    input  wire logic [NUM_PINS-1:0] extSwitch,
    input  wire logic                masterDominant,
    input  wire logic                masterWake,
    output logic      [NUM_PINS-1:0] pinIn,
    output logic                     busRxd,
    output logic                     busWake
);
    // closed low side wins; released pin shows the external contact
    assign pinIn = ~pinLsOn & (pinHsOn | extSwitch);
    // released bus goes recessive through the termination
    assign busRxd = ~masterDominant;
    assign busWake = masterWake; // wake sent ahead of any frame
endmodule : linio_far_side
`default_nettype wire

/* File: dv/tb_linio_pin_xcv_ctrl.sv */
// tb_linio_pin_xcv_ctrl: self-checking bench for pin and transceiver control
`timescale 1ns/1ps
`default_nettype none
module tb_linio_pin_xcv_ctrl
    import linio_pkg::*;
;
    localparam int DOM = 20;
    typedef struct {logic [7:0] hs, ls, lat, thr; logic cyc;
                    logic [7:0] eHs, eLs, e3;} linio_row_t;
    logic        clk, reset, regWrite, regRead, busRxd, busWake, oscFail, cyclicSense;
    logic        chainOut, inhibitOutput, inhibitOe, inhibitAdc, chainLsOn, txEnable, rxEnable;
    logic        busTerminationSwitch, weakTermination, wakeToCtrl, limpHome;
    logic        masterDominant, masterWake, got;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, rv;
    logic [7:0]  pinIn, pinHsOn, pinLsOn, thrSecond, thrThird, extSwitch;
    logic [2:0]  configPinPullup;
    int          n_mismatch, checked;
    linio_row_t  rows [5] = '{'{8'hf0, 8'hcc, 8'haa, 8'h00, 1'b0, 8'ha0, 8'h48, 8'h00},
        '{8'hf0, 8'hcc, 8'haa, 8'hff, 1'b1, 8'ha0, 8'h48, 8'h20},
        '{8'hf0, 8'hcc, 8'haa, 8'h0f, 1'b1, 8'ha0, 8'h48, 8'h00},
        '{8'hf0, 8'hcc, 8'haa, 8'hff, 1'b0, 8'ha0, 8'h48, 8'h00},
        '{8'h00, 8'h00, 8'hff, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00}};
    linio_pin_xcv_ctrl #(.DOM_TIMEOUT(DOM)) dut (.clk, .reset, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .pinIn, .busRxd, .busWake, .oscFail, .cyclicSense, .chainOut,
        .pinHsOn, .pinLsOn, .thrSecond, .thrThird, .inhibitOutput, .inhibitOe, .inhibitAdc,
        .configPinPullup, .chainLsOn, .txEnable, .rxEnable, .busTerminationSwitch,
        .weakTermination, .wakeToCtrl, .limpHome);
    linio_far_side far (.pinHsOn, .pinLsOn, .extSwitch, .masterDominant, .masterWake, .pinIn,
        .busRxd, .busWake);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        rv = regRdata;
    endtask : rd
    // wait, then look at settled outputs off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic waitWake(input logic exp);
        got = 1'b0;
        for (int i = 0; i < 30 && !got; i++) begin
            @(negedge clk);
            got = (wakeToCtrl === 1'b1);
        end
        chk({15'h0, got}, {15'h0, exp}, "wake pulse");
        @(posedge clk);
    endtask : waitWake
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {regWrite, regRead, oscFail, cyclicSense, chainOut, masterDominant, masterWake} = '0;
        {regAddr, regWdata, extSwitch} = '0;
        n_mismatch = 0;
        checked = 0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        settle(0);
        chk({inhibitOutput, inhibitOe, txEnable, rxEnable, weakTermination},
            16'h19, "rst");
        rd(ADDR_THR_SEL);
        chk(rv, 16'h0, "thr sel");
        rd(4'hf);
        chk(rv, 16'h0, "unmapped");
        $display("test reset finished");
        // table rows: driver decode and threshold choice per pin
        foreach (rows[i]) begin
            wr(ADDR_PIN_HS_EN, {8'h0, rows[i].hs});
            wr(ADDR_PIN_LS_EN, {8'h0, rows[i].ls});
            wr(ADDR_LATCH, {8'h0, rows[i].lat});
            wr(ADDR_THR_SEL, {8'h0, rows[i].thr});
            cyclicSense <= rows[i].cyc;
            settle(3);
            chk({pinHsOn, pinLsOn}, {rows[i].eHs, rows[i].eLs}, "drivers");
            chk({thrSecond, thrThird}, {rows[i].thr, rows[i].e3}, "thresholds");
        end
        $display("test pin table finished");
        // each capture mode against one rise and one fall of pin 0
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_EDGE_SEL, 16'(m));
            wr(ADDR_EDGE_FLAGS, 16'hffff);
            extSwitch <= 8'h01;
            settle(6);
            rd(ADDR_PIN_IN);
            chk(rv, 16'h0001, "pin in");
            rd(ADDR_EDGE_FLAGS);
            chk(rv, {15'h0, m[1]}, "rise flag");
            wr(ADDR_EDGE_FLAGS, 16'hffff);
            extSwitch <= 8'h00;
            settle(6);
            rd(ADDR_EDGE_FLAGS);
            chk(rv, {15'h0, m[0]}, "fall flag");
        end
        $display("test edge capture finished");
        wr(ADDR_INH_CTRL, 16'h0002);
        settle(3);
        chk({15'h0, inhibitOe}, 16'h0, "switch open");
        wr(ADDR_INH_CTRL, 16'h0001);
        settle(3);
        chk({15'h0, inhibitAdc}, 16'h1, "converter");
        wr(ADDR_INH_CTRL, 16'h0000);
        settle(3);
        chk({inhibitOe, inhibitOutput, inhibitAdc}, 16'h6, "regulator");
        wr(ADDR_MODE_CTRL, 16'h0004);
        settle(3);
        chk({configPinPullup, chainLsOn}, 16'he, "addr cfg");
        wr(ADDR_MODE_CTRL, 16'h0008);
        settle(3);
        chk({configPinPullup, chainLsOn}, 16'h1, "chain low");
        @(posedge clk);
        chainOut <= 1'b1;
        settle(3);
        chk({15'h0, chainLsOn}, 16'h0, "chain high");
        $display("test inhibit and config finished");
        // dominant runs: a broken one must not count, a long one must
        wr(ADDR_MODE_CTRL, 16'h0001);
        settle(6);
        chk({txEnable, rxEnable, busTerminationSwitch, weakTermination}, 16'he, "act");
        @(posedge clk);
        masterDominant <= 1'b1;
        repeat (DOM - 5) @(posedge clk);
        masterDominant <= 1'b0;
        repeat (2) @(posedge clk);
        masterDominant <= 1'b1;
        settle(DOM - 5);
        chk({15'h0, txEnable}, 16'h1, "short dominant");
        settle(15);
        chk({txEnable, busTerminationSwitch}, 16'h0, "timeout");
        rd(ADDR_STATUS);
        chk(rv, 16'h2, "fail silent");
        wr(ADDR_MODE_CTRL, 16'h0002);
        masterDominant <= 1'b0;
        settle(8);
        chk({txEnable, busTerminationSwitch, weakTermination}, 16'h1, "offline");
        @(posedge clk);
        masterWake <= 1'b1;
        waitWake(1'b1);
        masterWake <= 1'b0;
        settle(4);
        chk({15'h0, txEnable}, 16'h1, "woken");
        rd(ADDR_MODE_CTRL);
        chk(rv, 16'h0001, "normal");
        @(posedge clk);
        masterWake <= 1'b1;
        waitWake(1'b0);
        masterWake <= 1'b0;
        oscFail <= 1'b1;
        settle(8);
        chk({limpHome, txEnable, inhibitOe}, 16'h4, "limp home");
        $display("test transceiver finished");
        @(posedge clk);
        oscFail <= 1'b0;
        reset <= 1'b1;
        settle(2);
        chk({limpHome, inhibitOe, weakTermination, txEnable}, 16'h6, "second reset");
        @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_EDGE_SEL);
        chk(rv, RST_EDGE_SEL, "edge sel");
        $display("test mid-run reset finished");
        end_sim();
    end
endmodule : tb_linio_pin_xcv_ctrl
`default_nettype wire
